// *** hdl/scr_readout.sv ***
`timescale 1ns/10ps
`default_nettype none

module scr_lp_stage
  import scr_pkg::*;
#(
  parameter int W = FILT_W
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic [W-1:0] x,
  input wire logic [3:0] shift,
  output logic [W-1:0] y
);
  logic signed [W:0] diff;
  logic signed [W:0] step;
  logic signed [W+1:0] sum;

  assign diff = $signed({1'b0, x}) - $signed({1'b0, y});
  assign step = diff >>> shift;
  assign sum = $signed({2'b00, y}) + step;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      y <= '0;
    else if (en)
      y <= sum[W-1:0];
  end
endmodule

module scr_readout
  import scr_pkg::*;
#(
  parameter int unsigned SW_TICK_CYC = SW_TICK_CYCLES,
  parameter int unsigned SETTLE_TICKS_P = SETTLE_TICKS
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic temp_sel,
  input wire logic [2:0] bridge_filter_select,
  input wire logic [2:0] temp_filter_select,
  input wire logic [COEF_W-1:0] die_temp_offset_coeff,
  input wire logic [COEF_W-1:0] die_temp_slope_coeff,
  input wire logic die_temp_frame_12bit,
  input wire logic [2:0] rtd_sink_current_code,
  input wire logic [2:0] refres_first_gain_code,
  input wire logic [1:0] refres_second_gain_code,
  input wire logic [2:0] rtd_first_gain_code,
  input wire logic [1:0] rtd_second_gain_code,
  output logic adc_start,
  output logic [2:0] adc_channel,
  output logic adc_diff_mode,
  input wire logic adc_done,
  input wire logic [ADC_W-1:0] adc_data,
  input wire logic rd_req,
  input wire logic [7:0] rd_addr,
  output logic rd_valid,
  output logic [15:0] rd_data,
  output logic rd_err,
  input wire logic corr_req,
  output logic corr_valid,
  output logic [ADC_W-1:0] corr_bridge,
  output logic [ADC_W-1:0] corr_temp,
  output logic temp_frame_valid,
  output logic [11:0] temp_frame_data,
  input wire logic temp_frame_ready,
  output logic rtd_sink_enable,
  output logic [3:0] rtd_sink_tenths_ma,
  output logic [7:0] refres_gain_q,
  output logic [7:0] rtd_gain_q,
  output logic sw_filter_active
);
  localparam logic [10:0] BRIDGE_TICK_LAST = 11'(BRIDGE_TICK_CYCLES - 1);
  localparam logic [23:0] SW_TICK_LAST = 24'(SW_TICK_CYC - 1);
  localparam logic [15:0] SETTLE_LOAD = 16'(SETTLE_TICKS_P);
  localparam logic [1:0] ROT_LAST = 2'(TEMP_ROTATION - 1);

  // Gain codes in quarter V/V: stage values doubled, product doubled twice
  function automatic logic [7:0] g1x2(input logic [2:0] c);
    unique case (c)
      3'h0: g1x2 = 8'h02;
      3'h1: g1x2 = 8'h03;
      3'h2: g1x2 = 8'h04;
      3'h3: g1x2 = 8'h06;
      3'h4: g1x2 = 8'h08;
      3'h5: g1x2 = 8'h0C;
      3'h6: g1x2 = 8'h10;
      3'h7: g1x2 = 8'h18;
    endcase
  endfunction

  function automatic logic [7:0] g2x2(input logic [1:0] c);
    unique case (c)
      2'h0: g2x2 = 8'h02;
      2'h1: g2x2 = 8'h03;
      2'h2: g2x2 = 8'h04;
      2'h3: g2x2 = 8'h06;
    endcase
  endfunction

  function automatic logic [3:0] sw_shift(input logic [2:0] sel);
    case (sel)
      LPF_40: sw_shift = SH_40;
      LPF_2: sw_shift = SH_2;
      LPF_1: sw_shift = SH_1;
      LPF_0P3: sw_shift = SH_0P3;
      default: sw_shift = SH_100;
    endcase
  endfunction

  // Sequencer
  scr_seq_e seq_state;
  logic [10:0] tick_cnt;
  logic [1:0] slot;
  logic [1:0] rot;
  logic tick_pend;
  logic [2:0] cur_ch;
  wire bridge_tick = (tick_cnt == BRIDGE_TICK_LAST);
  wire take = (seq_state == SEQ_WAIT) && adc_done;
  wire [2:0] rot_ch = (rot == 2'h0) ? CH_DIE_TEMP :
                      (rot == 2'h1) ? CH_RTD :
                      (rot == 2'h2) ? CH_REFRES : CH_SELF_CHECK;
  wire [2:0] slot_ch = (slot == 2'h0) ? CH_BRIDGE_S3 :
                       (slot == 2'h1) ? CH_BRIDGE_S1 : rot_ch;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tick_cnt <= '0;
    else
      tick_cnt <= bridge_tick ? 11'h000 : tick_cnt + 11'h001;
  end

  // Two bridge slots every tick, temperatures rotate once per four ticks
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      seq_state <= SEQ_IDLE;
      slot <= 2'h0;
      rot <= 2'h0;
      tick_pend <= 1'b0;
      cur_ch <= CH_BRIDGE_S3;
    end
    else
    begin
      unique case (seq_state)
        SEQ_IDLE:
        begin
          tick_pend <= 1'b0;
          if (bridge_tick || tick_pend)
          begin
            slot <= 2'h0;
            seq_state <= SEQ_START;
          end
        end
        SEQ_START:
        begin
          tick_pend <= tick_pend | bridge_tick;
          cur_ch <= slot_ch;
          seq_state <= SEQ_WAIT;
        end
        SEQ_WAIT:
        begin
          tick_pend <= tick_pend | bridge_tick;
          if (adc_done)
          begin
            if (slot == 2'h2)
            begin
              rot <= (rot == ROT_LAST) ? 2'h0 : rot + 2'h1;
              seq_state <= SEQ_IDLE;
            end
            else
            begin
              slot <= slot + 2'h1;
              seq_state <= SEQ_START;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      adc_start <= 1'b0;
      adc_channel <= CH_BRIDGE_S3;
      adc_diff_mode <= 1'b0;
    end
    else
    begin
      adc_start <= (seq_state == SEQ_START);
      if (seq_state == SEQ_START)
      begin
        adc_channel <= slot_ch;
        adc_diff_mode <= (slot_ch == CH_BRIDGE_S1);
      end
    end
  end

  // Raw result registers, stored as converted, no correction
  logic [ADC_W-1:0] bridge_stage3_raw_result;
  logic [ADC_W-1:0] bridge_stage1_diff_result;
  logic [ADC_W-1:0] die_temperature_raw_result;
  logic [ADC_W-1:0] rtd_raw_result;
  logic [ADC_W-1:0] refres_raw_result;
  logic [ADC_W-1:0] self_check_raw_result;
  logic [3:0] sample_stb;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      bridge_stage3_raw_result <= ADC_SE_MIN;
      bridge_stage1_diff_result <= ADC_DIFF_ZERO;
      die_temperature_raw_result <= ADC_SE_MIN;
      rtd_raw_result <= ADC_SE_MIN;
      refres_raw_result <= ADC_SE_MIN;
      self_check_raw_result <= ADC_SE_MIN;
      sample_stb <= 4'h0;
    end
    else
    begin
      if (take && cur_ch == CH_BRIDGE_S3)
        bridge_stage3_raw_result <= adc_data;
      if (take && cur_ch == CH_BRIDGE_S1)
        bridge_stage1_diff_result <= adc_data;
      if (take && cur_ch == CH_DIE_TEMP)
        die_temperature_raw_result <= adc_data;
      if (take && cur_ch == CH_RTD)
        rtd_raw_result <= adc_data;
      if (take && cur_ch == CH_REFRES)
        refres_raw_result <= adc_data;
      if (take && cur_ch == CH_SELF_CHECK)
        self_check_raw_result <= adc_data;
      sample_stb <= {take && cur_ch == CH_REFRES, take && cur_ch == CH_RTD,
                     take && cur_ch == CH_DIE_TEMP, take && cur_ch == CH_BRIDGE_S3};
    end
  end

  // 4 kHz software filter rate and settling after reset or reselection
  logic [23:0] sw_cnt;
  logic [15:0] settle_cnt;
  logic [2:0] bsel_q;
  logic [2:0] tsel_q;
  wire sw_tick = (sw_cnt == SW_TICK_LAST);
  wire sel_change = (bsel_q != bridge_filter_select) || (tsel_q != temp_filter_select);
  // Codes 0, 6 and 7 leave a channel on its hardware filter
  wire sw_sel = (bsel_q >= LPF_100 && bsel_q <= LPF_0P3) ||
                (tsel_q >= LPF_100 && tsel_q <= LPF_0P3);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sw_cnt <= '0;
      settle_cnt <= SETTLE_LOAD;
      bsel_q <= LPF_HW;
      tsel_q <= LPF_HW;
      sw_filter_active <= 1'b0;
    end
    else
    begin
      sw_cnt <= sw_tick ? 24'h000000 : sw_cnt + 24'h000001;
      bsel_q <= bridge_filter_select;
      tsel_q <= temp_filter_select;
      if (sel_change)
        settle_cnt <= SETTLE_LOAD;
      else if (sw_tick && settle_cnt != 16'h0000)
        settle_cnt <= settle_cnt - 16'h0001;
      sw_filter_active <= (settle_cnt == 16'h0000) && !sel_change && sw_sel;
    end
  end

  // Channel 0 bridge, 1 die, 2 RTD, 3 reference resistor
  logic [3:0][ADC_W-1:0] ch_raw;
  logic [3:0][4:0][FILT_W-1:0] stg_y;
  logic [3:0][ADC_W-1:0] ch_filt;

  assign ch_raw = {refres_raw_result, rtd_raw_result,
                   die_temperature_raw_result, bridge_stage3_raw_result};

  for (genvar i = 0; i < 4; i++)
  begin : g_chan
    wire [2:0] sel = (i == 0) ? bsel_q : tsel_q;
    wire fourth = (sel == LPF_100) || (sel == LPF_40);
    wire first = (sel == LPF_2) || (sel == LPF_1) || (sel == LPF_0P3);
    wire [3:0] shs = sw_shift(sel);
    wire [FILT_W-1:0] chosen = !sw_filter_active ? stg_y[i][0] :
                                fourth ? stg_y[i][4] :
                                first ? stg_y[i][1] : stg_y[i][0];

    // Hardware filter at the channel's own sample rate
    scr_lp_stage #(.W(FILT_W)) u_hw (
      .clk(clk),
      .rst_n(rst_n),
      .en(sample_stb[i]),
      .x({ch_raw[i], {FRAC_W{1'b0}}}),
      .shift(SH_HW),
      .y(stg_y[i][0])
    );

    // Software cascade; fourth order approximated by four equal poles
    for (genvar j = 1; j < 5; j++)
    begin : g_sw
      scr_lp_stage #(.W(FILT_W)) u_sw (
        .clk(clk),
        .rst_n(rst_n),
        .en(sw_tick),
        .x(stg_y[i][j-1]),
        .shift(shs),
        .y(stg_y[i][j])
      );
    end

    assign ch_filt[i] = chosen[FILT_W-1 -: ADC_W];
  end

  // Bridge request for the correction engine
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      corr_valid <= 1'b0;
      corr_bridge <= ADC_SE_MIN;
      corr_temp <= ADC_SE_MIN;
    end
    else
    begin
      corr_valid <= corr_req;
      if (corr_req)
      begin
        corr_bridge <= ch_filt[0];
        corr_temp <= temp_sel ? ch_filt[2] : ch_filt[1];
      end
    end
  end

  // Die temperature scaling: (off*2^11 + slope*filtered die) / 2^23, times 4095
  wire signed [COEF_W-1:0] off_s = $signed(die_temp_offset_coeff);
  wire signed [COEF_W-1:0] slope_s = $signed(die_temp_slope_coeff);
  wire signed [28:0] norm_sum = 29'($signed({off_s, {OFFSET_ALIGN{1'b0}}}))
                              + 29'(slope_s * $signed({1'b0, ch_filt[1]}));
  wire signed [41:0] scaled = 42'(norm_sum * $signed(SCALE_MULT));
  wire signed [18:0] temp_int = 19'(scaled >>> NORM_SHIFT);
  wire [11:0] temp_sat = temp_int < 0 ? 12'h000 :
                         temp_int > $signed({7'h00, TEMP_OUT_MAX}) ? TEMP_OUT_MAX :
                         temp_int[11:0];
  wire [11:0] frame_word = die_temp_frame_12bit ? temp_sat
                         : 12'(temp_sat >> FRAME9_SHIFT);

  // Two-entry frame buffer; a full buffer holds the scaler back
  logic scale_pend;
  logic tail_valid;
  logic [11:0] tail_data;
  wire push = scale_pend && !tail_valid;
  wire pop = temp_frame_valid && temp_frame_ready;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      scale_pend <= 1'b0;
    else
      scale_pend <= sample_stb[1] | (scale_pend & ~push);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      temp_frame_valid <= 1'b0;
      temp_frame_data <= 12'h000;
      tail_valid <= 1'b0;
      tail_data <= 12'h000;
    end
    else if (!temp_frame_valid || pop)
    begin
      temp_frame_valid <= tail_valid || push;
      temp_frame_data <= tail_valid ? tail_data : frame_word;
      tail_valid <= 1'b0;
    end
    else if (push)
    begin
      tail_valid <= 1'b1;
      tail_data <= frame_word;
    end
  end

  // Diagnostic read of raw results
  wire hit_s3 = (rd_addr == SYSTEM_REGISTER_SPACE_BRIDGE_S3);
  wire hit_die = (rd_addr == SYSTEM_REGISTER_SPACE_DIE_TEMP);
  wire hit_rtd = (rd_addr == SYSTEM_REGISTER_SPACE_RTD);
  wire hit_ref = (rd_addr == SYSTEM_REGISTER_SPACE_REFRES);
  wire hit_s1 = (rd_addr == SYSTEM_REGISTER_SPACE_BRIDGE_S1);
  wire hit_self = (rd_addr == SYSTEM_REGISTER_SPACE_SELF_CHECK);
  wire rd_hit = hit_s3 | hit_die | hit_rtd | hit_ref | hit_s1 | hit_self;
  wire [ADC_W-1:0] rd_sel = hit_s3 ? bridge_stage3_raw_result :
                            hit_die ? die_temperature_raw_result :
                            hit_rtd ? rtd_raw_result :
                            hit_ref ? refres_raw_result :
                            hit_s1 ? bridge_stage1_diff_result :
                            hit_self ? self_check_raw_result : ADC_SE_MIN;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_valid <= 1'b0;
      rd_err <= 1'b0;
      rd_data <= 16'h0000;
    end
    else
    begin
      rd_valid <= rd_req;
      rd_err <= rd_req && !rd_hit;
      if (rd_req)
        rd_data <= {2'b00, rd_sel};
    end
  end

  // RTD front-end configuration
  wire [15:0] ref_prod = 16'(g1x2(refres_first_gain_code) * g2x2(refres_second_gain_code));
  wire [15:0] rtd_prod = 16'(g1x2(rtd_first_gain_code) * g2x2(rtd_second_gain_code));
  wire [3:0] sink_tenths = !rtd_sink_current_code[2] ? 4'h0 :
                           (rtd_sink_current_code[1:0] == 2'h0) ? 4'h1 :
                           (rtd_sink_current_code[1:0] == 2'h1) ? 4'h2 :
                           (rtd_sink_current_code[1:0] == 2'h2) ? 4'h5 : 4'hA;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rtd_sink_enable <= 1'b0;
      rtd_sink_tenths_ma <= 4'h0;
      refres_gain_q <= 8'h00;
      rtd_gain_q <= 8'h00;
    end
    else
    begin
      rtd_sink_enable <= rtd_sink_current_code[2];
      rtd_sink_tenths_ma <= sink_tenths;
      refres_gain_q <= ref_prod[7:0];
      rtd_gain_q <= rtd_prod[7:0];
    end
  end

endmodule

`default_nettype wire

// *** hdl/scr_pkg.sv ***
package scr_pkg;

  // Rates and derived cycle counts
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned BRIDGE_SAMPLE_HZ = 200_000;
  localparam int unsigned TEMP_SAMPLE_HZ = 50_000;
  localparam int unsigned SW_FILTER_HZ = 4_000;
  localparam int unsigned BRIDGE_TICK_CYCLES = CLK_HZ / BRIDGE_SAMPLE_HZ;
  localparam int unsigned TEMP_ROTATION = BRIDGE_SAMPLE_HZ / TEMP_SAMPLE_HZ;
  localparam int unsigned SW_TICK_CYCLES = CLK_HZ / SW_FILTER_HZ;
  localparam int unsigned SETTLE_TICKS = 4_000;

  // Data widths
  localparam int ADC_W = 14;
  localparam int FRAC_W = 12;
  localparam int FILT_W = ADC_W + FRAC_W;
  localparam int COEF_W = 12;

  // Converter code points
  localparam logic [13:0] ADC_SE_MIN = 14'h0000;
  localparam logic [13:0] ADC_SE_MAX = 14'h3FFF;
  localparam logic [13:0] ADC_DIFF_ZERO = 14'h2000;

  // System register space
  localparam logic [7:0] SYSTEM_REGISTER_SPACE_BRIDGE_S3 = 8'h90;
  localparam logic [7:0] SYSTEM_REGISTER_SPACE_DIE_TEMP = 8'h91;
  localparam logic [7:0] SYSTEM_REGISTER_SPACE_RTD = 8'h92;
  localparam logic [7:0] SYSTEM_REGISTER_SPACE_REFRES = 8'h93;
  localparam logic [7:0] SYSTEM_REGISTER_SPACE_BRIDGE_S1 = 8'h94;
  localparam logic [7:0] SYSTEM_REGISTER_SPACE_SELF_CHECK = 8'h95;

  // Converter channel codes
  localparam logic [2:0] CH_BRIDGE_S3 = 3'h0;
  localparam logic [2:0] CH_BRIDGE_S1 = 3'h1;
  localparam logic [2:0] CH_DIE_TEMP = 3'h2;
  localparam logic [2:0] CH_RTD = 3'h3;
  localparam logic [2:0] CH_REFRES = 3'h4;
  localparam logic [2:0] CH_SELF_CHECK = 3'h5;

  // Filter select codes
  localparam logic [2:0] LPF_HW = 3'h0;
  localparam logic [2:0] LPF_100 = 3'h1;
  localparam logic [2:0] LPF_40 = 3'h2;
  localparam logic [2:0] LPF_2 = 3'h3;
  localparam logic [2:0] LPF_1 = 3'h4;
  localparam logic [2:0] LPF_0P3 = 3'h5;

  // Filter coefficient shifts
  localparam logic [3:0] SH_HW = 4'h6;
  localparam logic [3:0] SH_100 = 4'h2;
  localparam logic [3:0] SH_40 = 4'h3;
  localparam logic [3:0] SH_2 = 4'h8;
  localparam logic [3:0] SH_1 = 4'h9;
  localparam logic [3:0] SH_0P3 = 4'hB;

  // Die temperature scaling
  localparam logic [12:0] SCALE_MULT = 13'h0FFF;
  localparam logic [11:0] TEMP_OUT_MAX = 12'hFFF;
  localparam int OFFSET_ALIGN = 11;
  localparam int NORM_SHIFT = 23;
  localparam int FRAME9_SHIFT = 3;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_START, SEQ_WAIT} scr_seq_e;

endpackage

// *** verif/scr_adc_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module scr_adc_model
  import scr_pkg::*;
(
  input wire logic clk,
  input wire logic adc_start,
  input wire logic [2:0] adc_channel,
  input wire logic slow,
  input wire logic [5:0][ADC_W-1:0] chan_val,
  output logic adc_done,
  output logic [ADC_W-1:0] adc_data
);
  int cnt = 0;
  logic [ADC_W-1:0] last = '0;

  initial
  begin
    adc_done = 1'b0;
    adc_data = '0;
  end

  // Data only valid with done; inverted junk otherwise
  always @(posedge clk)
  begin
    adc_done <= 1'b0;
    adc_data <= ~last;
    if (adc_start)
      cnt <= slow ? 20 : 1;
    else if (cnt == 1)
    begin
      adc_done <= 1'b1;
      adc_data <= chan_val[adc_channel];
      last <= chan_val[adc_channel];
      cnt <= 0;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule

`default_nettype wire

// *** verif/scr_readout_properties.sv ***
`timescale 1ns/10ps
`default_nettype none

module scr_readout_properties
  import scr_pkg::*;
#(
  parameter int unsigned SW_TICK_CYC = SW_TICK_CYCLES,
  parameter int unsigned SETTLE_TICKS_P = SETTLE_TICKS
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] rtd_sink_current_code,
  input wire logic [2:0] refres_first_gain_code,
  input wire logic [1:0] refres_second_gain_code,
  input wire logic adc_start,
  input wire logic [2:0] adc_channel,
  input wire logic adc_diff_mode,
  input wire logic adc_done,
  input wire logic rd_req,
  input wire logic [7:0] rd_addr,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  input wire logic rd_err,
  input wire logic corr_req,
  input wire logic corr_valid,
  input wire logic temp_frame_valid,
  input wire logic [11:0] temp_frame_data,
  input wire logic temp_frame_ready,
  input wire logic [3:0] rtd_sink_tenths_ma,
  input wire logic [7:0] refres_gain_q
);
  localparam logic [3:0] TENTHS [4] = '{4'h1, 4'h2, 4'h5, 4'hA};
  localparam logic [7:0] G1X2 [8] = '{8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h0C, 8'h10, 8'h18};
  localparam logic [7:0] G2X2 [4] = '{8'h02, 8'h03, 8'h04, 8'h06};
  wire logic [3:0] exp_tenths;
  wire logic [7:0] exp_gain;
  wire logic mapped;

  assign exp_tenths = rtd_sink_current_code[2] ? TENTHS[rtd_sink_current_code[1:0]] : 4'h0;
  assign exp_gain = 8'(G1X2[refres_first_gain_code] * G2X2[refres_second_gain_code]);
  assign mapped = rd_addr >= SYSTEM_REGISTER_SPACE_BRIDGE_S3 && rd_addr <= SYSTEM_REGISTER_SPACE_SELF_CHECK;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_s3_done;
    adc_done && adc_channel == CH_BRIDGE_S3;
  endsequence
  sequence s_s1_start;
    adc_start && adc_channel == CH_BRIDGE_S1 && adc_diff_mode;
  endsequence

  property p_s1_follows;
    s_s3_done |-> ##2 s_s1_start;
  endproperty
  a_s1_follows: assert property (p_s1_follows)
    else $error("stage one conversion did not follow stage three");
  property p_diff_mode;
    adc_start |-> adc_diff_mode == (adc_channel == CH_BRIDGE_S1);
  endproperty
  a_diff_mode: assert property (p_diff_mode)
    else $error("conversion mode wrong for channel");
  property p_start_pulse;
    adc_start |=> !adc_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start longer than one cycle");
  property p_rd_ok;
    rd_req && mapped |=> rd_valid && !rd_err;
  endproperty
  a_rd_ok: assert property (p_rd_ok)
    else $error("mapped read not answered");
  property p_rd_bad;
    rd_req && !mapped |=> rd_err && rd_data == 16'h0000;
  endproperty
  a_rd_bad: assert property (p_rd_bad)
    else $error("unmapped read not refused");
  property p_corr_ans;
    corr_req |=> corr_valid;
  endproperty
  a_corr_ans: assert property (p_corr_ans)
    else $error("correction not answered");
  property p_corr_only;
    corr_valid |-> $past(corr_req);
  endproperty
  a_corr_only: assert property (p_corr_only)
    else $error("correction result without request");
  property p_frame_hold;
    temp_frame_valid && !temp_frame_ready |=> temp_frame_valid && $stable(temp_frame_data);
  endproperty
  a_frame_hold: assert property (p_frame_hold)
    else $error("stalled frame changed");
  property p_sink;
    $stable(rtd_sink_current_code) |=> rtd_sink_tenths_ma == $past(exp_tenths);
  endproperty
  a_sink: assert property (p_sink)
    else $error("sink current code decoded wrongly");
  property p_gain;
    $stable(refres_first_gain_code) && $stable(refres_second_gain_code)
      |=> refres_gain_q == $past(exp_gain);
  endproperty
  a_gain: assert property (p_gain)
    else $error("reference gain product wrong");
endmodule

bind scr_readout scr_readout_properties #(
  .SW_TICK_CYC(SW_TICK_CYC),
  .SETTLE_TICKS_P(SETTLE_TICKS_P)
) u_props (
  .clk(clk),
  .rst_n(rst_n),
  .rtd_sink_current_code(rtd_sink_current_code),
  .refres_first_gain_code(refres_first_gain_code),
  .refres_second_gain_code(refres_second_gain_code),
  .adc_start(adc_start),
  .adc_channel(adc_channel),
  .adc_diff_mode(adc_diff_mode),
  .adc_done(adc_done),
  .rd_req(rd_req),
  .rd_addr(rd_addr),
  .rd_valid(rd_valid),
  .rd_data(rd_data),
  .rd_err(rd_err),
  .corr_req(corr_req),
  .corr_valid(corr_valid),
  .temp_frame_valid(temp_frame_valid),
  .temp_frame_data(temp_frame_data),
  .temp_frame_ready(temp_frame_ready),
  .rtd_sink_tenths_ma(rtd_sink_tenths_ma),
  .refres_gain_q(refres_gain_q)
);

`default_nettype wire

// *** verif/scr_readout_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none

module scr_readout_tb_top
  import scr_pkg::*;
;
  localparam logic [3:0] TEN [8] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h2, 4'h5, 4'hA};
  localparam logic [7:0] G1 [8] = '{8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h0C, 8'h10, 8'h18};
  localparam logic [7:0] G2 [4] = '{8'h02, 8'h03, 8'h04, 8'h06};
  localparam logic [7:0] RAW_ADDR [6] = '{SYSTEM_REGISTER_SPACE_BRIDGE_S3, SYSTEM_REGISTER_SPACE_BRIDGE_S1, SYSTEM_REGISTER_SPACE_DIE_TEMP,
    SYSTEM_REGISTER_SPACE_RTD, SYSTEM_REGISTER_SPACE_REFRES, SYSTEM_REGISTER_SPACE_SELF_CHECK};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic temp_sel = 1'b0;
  logic [2:0] bridge_filter_select = 3'h0;
  logic [2:0] temp_filter_select = 3'h0;
  logic [11:0] die_temp_offset_coeff = 12'h7FF;
  logic [11:0] die_temp_slope_coeff = 12'h498;
  logic die_temp_frame_12bit = 1'b1;
  logic [2:0] rtd_sink_current_code = 3'h0;
  logic [2:0] refres_first_gain_code = 3'h0;
  logic [1:0] refres_second_gain_code = 2'h0;
  logic [2:0] rtd_first_gain_code = 3'h0;
  logic [1:0] rtd_second_gain_code = 2'h0;
  logic rd_req = 1'b0;
  logic [7:0] rd_addr = 8'h00;
  logic corr_req = 1'b0;
  logic temp_frame_ready = 1'b1;
  logic slow = 1'b0;
  // Die input left at zero so its filter output stays exactly zero
  logic [5:0][13:0] chan_val = {14'h1555, 14'h0F0F, 14'h3FFF, 14'h0000, 14'h2ABC, 14'h1234};
  logic adc_start, adc_diff_mode, adc_done, rd_valid, rd_err, corr_valid;
  logic temp_frame_valid, rtd_sink_enable, sw_filter_active;
  logic [2:0] adc_channel;
  logic [13:0] adc_data, corr_bridge, corr_temp;
  logic [15:0] rd_data;
  logic [11:0] temp_frame_data;
  logic [3:0] rtd_sink_tenths_ma;
  logic [7:0] refres_gain_q, rtd_gain_q;
  int miscompares = 0;
  int comparisons = 0;

  initial
  begin
    forever #2 clk = ~clk;
  end

  scr_readout #(.SW_TICK_CYC(50), .SETTLE_TICKS_P(3)) dut (
    .clk(clk), .rst_n(rst_n), .temp_sel(temp_sel),
    .bridge_filter_select(bridge_filter_select), .temp_filter_select(temp_filter_select),
    .die_temp_offset_coeff(die_temp_offset_coeff), .die_temp_slope_coeff(die_temp_slope_coeff),
    .die_temp_frame_12bit(die_temp_frame_12bit), .rtd_sink_current_code(rtd_sink_current_code),
    .refres_first_gain_code(refres_first_gain_code),
    .refres_second_gain_code(refres_second_gain_code),
    .rtd_first_gain_code(rtd_first_gain_code), .rtd_second_gain_code(rtd_second_gain_code),
    .adc_start(adc_start), .adc_channel(adc_channel), .adc_diff_mode(adc_diff_mode),
    .adc_done(adc_done), .adc_data(adc_data), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_valid(rd_valid), .rd_data(rd_data), .rd_err(rd_err), .corr_req(corr_req),
    .corr_valid(corr_valid), .corr_bridge(corr_bridge), .corr_temp(corr_temp),
    .temp_frame_valid(temp_frame_valid), .temp_frame_data(temp_frame_data),
    .temp_frame_ready(temp_frame_ready), .rtd_sink_enable(rtd_sink_enable),
    .rtd_sink_tenths_ma(rtd_sink_tenths_ma), .refres_gain_q(refres_gain_q),
    .rtd_gain_q(rtd_gain_q), .sw_filter_active(sw_filter_active)
  );

  scr_adc_model u_adc (
    .clk(clk), .adc_start(adc_start), .adc_channel(adc_channel), .slow(slow),
    .chan_val(chan_val), .adc_done(adc_done), .adc_data(adc_data)
  );

  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Bounded wait; sel 0 frame valid, 1 software filter flag
  task automatic wait_hi(input int sel, input int lim);
    for (int i = 0; i < lim; i++)
    begin
      @(posedge clk);
      #1;
      if ((sel == 0 ? temp_frame_valid : sw_filter_active) === 1'b1)
      begin
        comparisons++;
        return;
      end
    end
    check("wait_timeout", 16'h0, 16'h1);
    give_verdict();
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input logic err);
    @(posedge clk);
    rd_req <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_req <= 1'b0;
    #1;
    check("rd_err", {15'h0, rd_err}, {15'h0, err});
    check("rd_data", rd_data, exp);
    check("rd_valid", {15'h0, rd_valid}, 16'h1);
  endtask

  task automatic pop(input logic [15:0] exp);
    wait_hi(0, 6000);
    check("frame", {4'h0, temp_frame_data}, exp);
    @(posedge clk);
    temp_frame_ready <= 1'b1;
    @(posedge clk);
    temp_frame_ready <= 1'b0;
  endtask

  task automatic t_reset();
    check("sw_active", {15'h0, sw_filter_active}, 16'h0);
    rd(SYSTEM_REGISTER_SPACE_BRIDGE_S1, {2'b0, ADC_DIFF_ZERO}, 1'b0);
    rd(SYSTEM_REGISTER_SPACE_BRIDGE_S3, {2'b0, ADC_SE_MIN}, 1'b0);
  endtask

  task automatic t_codes();
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      rtd_sink_current_code <= 3'(i);
      refres_first_gain_code <= 3'(i);
      refres_second_gain_code <= 2'(i);
      rtd_first_gain_code <= 3'(7 - i);
      rtd_second_gain_code <= 2'(7 - i);
      cyc(3);
      #1;
      check("sink_en", {15'h0, rtd_sink_enable}, {15'h0, i >= 4});
      check("sink_ma", {12'h0, rtd_sink_tenths_ma}, {12'h0, TEN[i]});
      check("ref_gain", {8'h0, refres_gain_q}, {8'h0, G1[i] * G2[i % 4]});
      check("rtd_gain", {8'h0, rtd_gain_q}, {8'h0, G1[7 - i] * G2[(7 - i) % 4]});
    end
  endtask

  task automatic t_raw();
    @(posedge clk);
    slow <= 1'b1;
    // Six bridge ticks cover the four-tick temperature rotation
    cyc(7500);
    for (int c = 0; c < 6; c++)
      rd(RAW_ADDR[c], {2'b0, chan_val[c]}, 1'b0);
    rd(8'h8F, 16'h0, 1'b1);
    rd(8'h96, 16'h0, 1'b1);
  endtask

  task automatic t_frames();
    @(posedge clk);
    temp_frame_ready <= 1'b0;
    wait_hi(0, 6000);
    check("frame_12", {4'h0, temp_frame_data}, 16'd2046);
    @(posedge clk);
    die_temp_offset_coeff <= 12'h800;
    // Two more die samples arrive while stalled: tail fills, the other stays pending
    cyc(10200);
    pop(16'd2046);
    pop(16'h0);
    pop(16'h0);
    @(posedge clk);
    die_temp_offset_coeff <= 12'h7FF;
    die_temp_frame_12bit <= 1'b0;
    pop(16'd255);
    @(posedge clk);
    temp_frame_ready <= 1'b1;
  endtask

  task automatic t_filters();
    for (int k = 1; k < 6; k++)
    begin
      @(posedge clk);
      bridge_filter_select <= 3'(k);
      temp_filter_select <= 3'(6 - k);
      cyc(2);
      #1;
      check("sw_settling", {15'h0, sw_filter_active}, 16'h0);
      wait_hi(1, 400);
    end
    @(posedge clk);
    bridge_filter_select <= 3'h7;
    temp_filter_select <= LPF_HW;
    cyc(400);
    #1;
    check("sw_off", {15'h0, sw_filter_active}, 16'h0);
  endtask

  task automatic t_corr();
    for (int s = 0; s < 2; s++)
    begin
      @(posedge clk);
      temp_sel <= s[0];
      corr_req <= 1'b1;
      cyc(2);
      corr_req <= 1'b0;
      #1;
      check("corr_valid", {15'h0, corr_valid}, 16'h1);
      check("corr_temp_src", {15'h0, corr_temp != 14'h0}, {15'h0, s[0]});
      check("corr_bridge", {15'h0, |corr_bridge && corr_bridge <= chan_val[0]}, 16'h1);
    end
    cyc(3);
    #1;
    check("corr_idle", {15'h0, corr_valid}, 16'h0);
  endtask

  initial
  begin
    cyc(12);
    rst_n <= 1'b1;
    cyc(2);
    #1;
    t_reset();
    t_codes();
    t_raw();
    t_frames();
    t_filters();
    t_corr();
    give_verdict();
  end
endmodule

`default_nettype wire
